/* File: inc/lomix_pkg.sv */
package lomix_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFF_LAMP_MIX = 8'h58;
  localparam logic [7:0] OFF_LDAC1_MIX = 8'h59;
  localparam logic [7:0] OFF_SECOND_RIGHT_LINE_INPUT_MIX = 8'h5A;
  localparam logic [7:0] OFF_RAMP_MIX = 8'h5B;
  localparam logic [7:0] OFF_RDAC1_MIX = 8'h5C;
  localparam logic [7:0] OFF_LEVEL = 8'h5D;
  localparam logic [7:0] OFF_PWR = 8'h5E;
  localparam logic [7:0] OFF_SC = 8'h5F;
  localparam logic [7:0] OFF_STICKY = 8'h60;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int NUM_SRC = 5;
  localparam int VOL_W = 7;
  localparam int ROUTE_BIT = 7;
  localparam int VOL_MSB = 6;
  localparam int LVL_MSB = 7;
  localparam int LVL_LSB = 4;
  localparam int MUTE_BIT = 3;
  localparam int RSV_BIT = 2;
  localparam int BUSY_BIT = 1;
  localparam int PWR_BIT = 0;
  localparam int HPR_BIT = 1;

  // ****************************************
  // Status vector layout after the synchroniser
  // ****************************************
  localparam int STAT_W = 17;
  localparam int ST_PWR_MSB = 16;
  localparam int ST_PWR_LSB = 12;
  localparam int ST_HPL = 11;
  localparam int ST_HPR = 10;
  localparam int ST_DRV_MSB = 9;
  localparam int ST_DRV_LSB = 4;
  localparam int ST_SC_MSB = 9;
  localparam int ST_SC_LSB = 6;
  localparam int ST_BTN = 3;
  localparam int ST_HSET = 2;
  localparam int ST_AGC_L = 1;
  localparam int ST_AGC_R = 0;
  localparam int STK_SC_MSB = 7;
  localparam int STK_SC_LSB = 4;
  localparam int STK_BTN = 3;
  localparam int STK_HSET = 2;
  localparam int STK_AGC_L = 1;
  localparam int STK_AGC_R = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] RAMP_RELOAD = 7'(RAMP_STEP_CYC - 1);

endpackage

/* File: core/sync_filter.sv */
`timescale 1ns/1ps
module sync_filter
  import lomix_pkg::*;
#(
  parameter int WIDTH = STAT_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Asynchronous levels in, settled levels out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // A bit moves only once stages two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt = (st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3));
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.filt;

endmodule

/* File: core/line_out_mix_status_regs.sv */
`timescale 1ns/1ps
module line_out_mix_status_regs
  import lomix_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port from the control bus
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Analog power status levels
  input wire logic left_dac_powered,
  input wire logic right_dac_powered,
  input wire logic mono_line_output_powered,
  input wire logic left_line_output_powered,
  input wire logic right_line_output_powered,
  input wire logic left_headphone_driver_powered,
  input wire logic right_headphone_driver_powered,
  input wire logic left_common_driver_powered,
  input wire logic right_common_driver_powered,
  // Short-circuit detector levels
  input wire logic left_headphone_driver_short,
  input wire logic right_headphone_driver_short,
  input wire logic left_common_driver_short,
  input wire logic right_common_driver_short,
  // Headset and record noise gate levels
  input wire logic button_pressed,
  input wire logic headset_present,
  input wire logic left_agc_below_noise,
  input wire logic right_agc_below_noise,
  // Right line output mixer controls
  output logic [NUM_SRC-1:0] mix_route,
  output logic [NUM_SRC*VOL_W-1:0] mix_gain,
  output logic [3:0] line_level,
  output logic line_unmute,
  output logic line_power_req
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NUM_SRC-1:0] route;
    logic [NUM_SRC-1:0][VOL_W-1:0] target;
    logic [NUM_SRC-1:0][VOL_W-1:0] applied;
    logic [6:0] step_cnt;
    logic busy;
    logic [3:0] level;
    logic unmute;
    logic power;
    logic hpr_stat;
    logic [7:0] sticky;
    logic hset_prev;
    logic [7:0] rdata;
    logic rvalid;
  } bank_state_t;

  bank_state_t st;
  bank_state_t next_st;
  logic [STAT_W-1:0] raw_stat;
  logic [STAT_W-1:0] stat;
  logic [7:0] sticky_set;
  logic [7:0] sticky_clr;
  logic [2:0] src_idx;
  logic ramp_tick;
  logic mix_hit;

  // Order matches the bit order of the status registers
  assign raw_stat = {left_dac_powered, right_dac_powered, mono_line_output_powered,
    left_line_output_powered, right_line_output_powered,
    left_headphone_driver_powered, right_headphone_driver_powered,
    left_headphone_driver_short, right_headphone_driver_short,
    left_common_driver_short, right_common_driver_short,
    left_common_driver_powered, right_common_driver_powered,
    button_pressed, headset_present, left_agc_below_noise, right_agc_below_noise};

  sync_filter #(
    .WIDTH(STAT_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(raw_stat),
    .dout(stat)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    src_idx = 3'(reg_addr - OFF_LAMP_MIX);
    mix_hit = (reg_addr >= OFF_LAMP_MIX) && (reg_addr <= OFF_RDAC1_MIX);

    // Hardware refreshes the headphone bit; a host write only holds for one cycle
    next_st.hpr_stat = stat[ST_HPR];

    if (reg_wr) begin
      if (mix_hit) begin
        next_st.route[src_idx] = reg_wdata[ROUTE_BIT];
        next_st.target[src_idx] = reg_wdata[VOL_MSB:0];
      end else if (reg_addr == OFF_LEVEL) begin
        next_st.level = reg_wdata[LVL_MSB:LVL_LSB];
        next_st.unmute = reg_wdata[MUTE_BIT];
        next_st.power = reg_wdata[PWR_BIT];
      end else if (reg_addr == OFF_PWR) begin
        next_st.hpr_stat = reg_wdata[HPR_BIT];
      end
    end

    // Gains walk one code per step so changes do not click
    ramp_tick = (st.step_cnt == 7'h00);
    next_st.step_cnt = ramp_tick ? RAMP_RELOAD : st.step_cnt - 7'h01;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (ramp_tick && (st.applied[i] < st.target[i])) begin
        next_st.applied[i] = st.applied[i] + 7'h01;
      end else if (ramp_tick && (st.applied[i] > st.target[i])) begin
        next_st.applied[i] = st.applied[i] - 7'h01;
      end
    end
    next_st.busy = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (next_st.applied[i] != next_st.target[i]) begin
        next_st.busy = 1'b1;
      end
    end

    // Sticky flags: a set in the clearing cycle survives
    sticky_set = 8'h00;
    sticky_set[STK_SC_MSB:STK_SC_LSB] = stat[ST_SC_MSB:ST_SC_LSB];
    sticky_set[STK_BTN] = stat[ST_BTN];
    sticky_set[STK_HSET] = stat[ST_HSET] ^ st.hset_prev;
    sticky_set[STK_AGC_L] = stat[ST_AGC_L];
    sticky_set[STK_AGC_R] = stat[ST_AGC_R];
    sticky_clr = (reg_rd && (reg_addr == OFF_STICKY)) ? 8'hFF : 8'h00;
    next_st.sticky = (st.sticky & ~sticky_clr) | sticky_set;
    next_st.hset_prev = stat[ST_HSET];

    if (reg_rd) begin
      next_st.rvalid = 1'b1;
      if (mix_hit) begin
        next_st.rdata = {st.route[src_idx], st.target[src_idx]};
      end else if (reg_addr == OFF_LEVEL) begin
        // Reserved bit reads zero whatever was written
        next_st.rdata = {st.level, st.unmute, 1'b0, st.busy, st.power};
      end else if (reg_addr == OFF_PWR) begin
        next_st.rdata = {stat[ST_PWR_MSB:ST_PWR_LSB], stat[ST_HPL], st.hpr_stat,
          1'b0};
      end else if (reg_addr == OFF_SC) begin
        next_st.rdata = {stat[ST_DRV_MSB:ST_DRV_LSB], 2'b00};
      end else if (reg_addr == OFF_STICKY) begin
        next_st.rdata = st.sticky;
      end else begin
        next_st.rdata = RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign mix_route = st.route;
  assign mix_gain = st.applied;
  assign line_level = st.level;
  assign line_unmute = st.unmute;
  assign line_power_req = st.power;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence wr_at(logic [7:0] a);
    reg_wr && (reg_addr == a);
  endsequence

  sequence rd_at(logic [7:0] a);
    reg_rd && (reg_addr == a);
  endsequence

  sequence rd_only_at(logic [7:0] a);
    reg_rd && !reg_wr && (reg_addr == a);
  endsequence

  read_answer_a: assert property (reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd)))
    else $error("read answer not one cycle after strobe");

  route_write_a: assert property (
    wr_at(OFF_LDAC1_MIX) |=> mix_route[1] == $past(reg_wdata[ROUTE_BIT]))
    else $error("route bit not stored");

  route_reset_a: assert property (
    $rose(rst_n) |-> mix_route == '0)
    else $error("source routed after reset");

  vol_readback_a: assert property (
    (wr_at(OFF_LAMP_MIX) ##1 rd_only_at(OFF_LAMP_MIX))
      |=> reg_rdata[VOL_MSB:0] == $past(reg_wdata[VOL_MSB:0], 2))
    else $error("volume not read back");

  ramp_step_a: assert property (
    !ramp_tick |=> $stable(mix_gain))
    else $error("gain moved between steps");

  level_write_a: assert property (
    wr_at(OFF_LEVEL) |=> line_level == $past(reg_wdata[LVL_MSB:LVL_LSB]))
    else $error("level field not stored");

  mute_write_a: assert property (
    wr_at(OFF_LEVEL) |=> line_unmute == $past(reg_wdata[MUTE_BIT]))
    else $error("mute bit not stored");

  power_write_a: assert property (
    wr_at(OFF_LEVEL) |=> line_power_req == $past(reg_wdata[PWR_BIT]))
    else $error("power bit not stored");

  level_read_a: assert property (
    rd_at(OFF_LEVEL) |=> reg_rdata[BUSY_BIT] == $past(st.busy)
      && reg_rdata[RSV_BIT] == 1'b0)
    else $error("busy or reserved bit read wrong");

  busy_meaning_a: assert property (
    !st.busy |-> st.applied == st.target)
    else $error("idle while gains still pending");

  pwr_read_a: assert property (
    rd_at(OFF_PWR) |=> reg_rdata[7:3] == $past(stat[ST_PWR_MSB:ST_PWR_LSB])
      && reg_rdata[0] == 1'b0)
    else $error("power status read wrong");

  sc_read_a: assert property (
    rd_at(OFF_SC) |=> reg_rdata == {$past(stat[ST_DRV_MSB:ST_DRV_LSB]), 2'b00})
    else $error("short-circuit status read wrong");

  sc_sticky_a: assert property (
    stat[ST_SC_MSB:ST_SC_LSB] != 4'h0
      |=> (($past(stat[ST_SC_MSB:ST_SC_LSB]) & ~st.sticky[STK_SC_MSB:STK_SC_LSB]) == 4'h0))
    else $error("short event not flagged");

  button_sticky_a: assert property (
    stat[ST_BTN] |=> st.sticky[STK_BTN])
    else $error("button press not flagged");

  headset_edge_a: assert property (
    $changed(stat[ST_HSET]) |=> st.sticky[STK_HSET])
    else $error("headset change not flagged");

  agc_sticky_a: assert property (
    (stat[ST_AGC_L] |=> st.sticky[STK_AGC_L]) and (stat[ST_AGC_R] |=> st.sticky[STK_AGC_R]))
    else $error("noise gate not flagged");

  sticky_hold_a: assert property (
    !(reg_rd && (reg_addr == OFF_STICKY)) |=> (st.sticky & $past(st.sticky)) == $past(st.sticky))
    else $error("sticky flag lost without read");

  sticky_read_a: assert property (
    rd_at(OFF_STICKY) && (stat == '0) && !st.hset_prev
      |=> reg_rdata == $past(st.sticky) && st.sticky == 8'h00)
    else $error("sticky read did not return and clear");

endmodule

/* File: test/host_model.sv */
`timescale 1ns/1ps
module host_model
  import lomix_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register port toward the bank
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // ****************************************
  // Write: sanitised the way a careful host would
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == OFF_LEVEL && v[7:4] > 4'h9) v[7:4] = 4'h9;
    if (a == OFF_LEVEL) v[RSV_BIT] = 1'b0;
    if (a == OFF_PWR) v[0] = 1'b0;
    if (a != OFF_SC) begin
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      // Idle lines scrambled so a stale value is never trusted
      reg_addr <= ~a;
      reg_wdata <= ~v;
    end
  endtask

  // ****************************************
  // Read: answer expected one cycle later
  // ****************************************
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (int n = 0; n < 4 && !ok; n++) begin
      #1;
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        ok = 1'b1;
      end else begin
        @(posedge clk_sys);
      end
    end
  endtask
endmodule

/* File: test/tb_line_out_mix_status_regs.sv */
`timescale 1ns/1ps
module tb_line_out_mix_status_regs
  import lomix_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [16:0] st = '0;
  logic [NUM_SRC-1:0] mix_route;
  logic [NUM_SRC*VOL_W-1:0] mix_gain;
  logic [3:0] line_level;
  logic line_unmute;
  logic line_power_req;
  int num_errors = 0;
  int check_count = 0;
  logic [31:0] seed = 32'hFB527C3D;
  int tgt[NUM_SRC];
  int n;
  logic [NUM_SRC-1:0] er;
  logic [NUM_SRC*VOL_W-1:0] eg;
  logic [7:0] rv;
  bit ok;

  always #5 clk_sys = ~clk_sys;

  host_model host_u (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  line_out_mix_status_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .left_dac_powered(st[16]), .right_dac_powered(st[15]),
    .mono_line_output_powered(st[14]), .left_line_output_powered(st[13]),
    .right_line_output_powered(st[12]), .left_headphone_driver_powered(st[11]),
    .right_headphone_driver_powered(st[10]), .left_common_driver_powered(st[9]),
    .right_common_driver_powered(st[8]), .left_headphone_driver_short(st[7]),
    .right_headphone_driver_short(st[6]), .left_common_driver_short(st[5]),
    .right_common_driver_short(st[4]), .button_pressed(st[3]), .headset_present(st[2]),
    .left_agc_below_noise(st[1]), .right_agc_below_noise(st[0]), .mix_route(mix_route),
    .mix_gain(mix_gain), .line_level(line_level), .line_unmute(line_unmute),
    .line_power_req(line_power_req));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic results();
    $display("Checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    host_u.rd(a, rv, ok);
    if (!ok) begin
      num_errors++;
      $display("Error %s read answer missing", name);
      results();
    end
    check(name, 64'(rv), 64'(exp));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check("outputs", 64'({mix_route, mix_gain, line_level, line_unmute, line_power_req}), 0);
    for (int a = 32'h58; a <= 32'h61; a++) rdchk(8'(a), 8'h00, "reset value");
    $display("test reset done");

    // Random mixer settings, last source far from zero so the ramp is long
    for (int i = 0; i < NUM_SRC; i++) begin
      seed = lfsr_next(seed);
      tgt[i] = int'(seed[7:0]);
      if (i == NUM_SRC - 1) tgt[i] = tgt[i] | 32'h40;
      host_u.wr(OFF_LAMP_MIX + 8'(i), 8'(tgt[i]));
      er[i] = tgt[i][7];
      eg[VOL_W*i +: VOL_W] = 7'(tgt[i]);
    end
    rdchk(OFF_LEVEL, 8'h02, "busy while ramping");
    for (int i = 0; i < NUM_SRC; i++) rdchk(OFF_LAMP_MIX + 8'(i), 8'(tgt[i]), "mixer");
    check("route", 64'(mix_route), 64'(er));
    // Look past the edge so the gain launched on it has settled
    for (n = 0; n < 13000 && mix_gain !== eg; n++) begin
      @(posedge clk_sys);
      #1;
    end
    if (n == 13000) begin
      num_errors++;
      $display("Error ramp never settled");
      results();
    end
    #1;
    check("gain", 64'(mix_gain), 64'(eg));
    rdchk(OFF_LEVEL, 8'h00, "busy cleared");
    $display("test mixer done");

    // Every legal level code; read-only bit written high must not stick
    for (int c = 0; c < 10; c++) begin
      host_u.wr(OFF_LEVEL, {4'(c), 1'(c % 2), 2'b11, 1'((c / 2) % 2)});
      #1;
      check("level", 64'({line_level, line_unmute, line_power_req}),
        64'({4'(c), 1'(c % 2), 1'((c / 2) % 2)}));
      rdchk(OFF_LEVEL, {4'(c), 1'(c % 2), 2'b00, 1'((c / 2) % 2)}, "level readback");
    end
    host_u.wr(8'h61, 8'hFF);
    rdchk(8'h61, 8'h00, "unmapped");
    $display("test level done");

    repeat (4) begin
      seed = lfsr_next(seed);
      @(posedge clk_sys);
      st <= seed[16:0];
      repeat (8) @(posedge clk_sys);
      rdchk(OFF_PWR, {st[16:10], 1'b0}, "power status");
      rdchk(OFF_SC, {st[7:4], st[9:8], 2'b00}, "short status");
    end
    $display("test status done");

    @(posedge clk_sys);
    st <= '0;
    repeat (8) @(posedge clk_sys);
    // Flush flags left by the random status pass
    host_u.rd(OFF_STICKY, rv, ok);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      st <= 17'(1 << i);
      repeat (8) @(posedge clk_sys);
      st <= '0;
      repeat (8) @(posedge clk_sys);
      rdchk(OFF_STICKY, 8'(1 << i), "sticky set");
      rdchk(OFF_STICKY, 8'h00, "sticky cleared");
    end
    $display("test sticky done");
    results();
  end
endmodule
